// *** rtl/dimmer_pkg.sv ***
/*
  Constants, register map and carrier types for the eight-channel LED
  bypass dimmer control block.
  Assumes a single 20 MHz system clock and a plain register port.
*/
// Contract
// - alert output pulled low while any open, short or overheat fault is latched; code: pulled low on a new fault, released by ARA or clear write
// - alert released after address sent on alert response or fault cleared by write
// - alert response answered with this device's own address
// - enable rising edge restores power-on state, all registers at default
// - register access works while enable is low; such writes lost at enable rise
// - shutdown reads all fault status bits as one, alert released; code: overheat bit in misc status reads its latched flag
// - shutdown holds all bypass switches off, alert function disabled
// - dimming cycle equals timebase frequency divided by 2048
// - toggling timebase pin replaces internal oscillator as timebase
// - all-channel group address is 010 followed by four select bits
// - per-channel group address is 101 followed by select bits
// - four select pins form variable bits, fourth most significant, default 1111
// - open threshold has four choices, default 18V or 9V by variant
// - open fault while enabled turns that channel's bypass switch on
// - open fault suspends channel dimming until cleared over the bus
// - short detector flags one to four shorted LEDs, single by default
// - short threshold select picks 1V or reference times one to three plus 1V
// - short fault leaves programmed dimming of the channel running
// - die overheat reported in fault status with LED faults; code: overheat bit sits in the separate misc status register
// - nine command registers and two read-only fault status registers, all readable; code: ten command, three status, open/short/overheat bits write 1 to clear
// - any register accessed directly in any order
// - variants differ only in command register defaults
// - channel counters start one-eighth cycle apart from neighbours
// - LEDs on at cycle start, off when counter matches dimming value
`default_nettype none

package dimmer_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int          ADDR_W          = 4;
  localparam int          DATA_W          = 8;
  localparam int          NUM_CH          = 8;
  localparam int          CNT_W           = 11;
  localparam logic [3:0]  OFS_ALL_CH      = 4'h0;  // all-channel on/off bits
  localparam logic [3:0]  OFS_DIM_FIRST   = 4'h1;  // channel dimming values 1..8
  localparam logic [3:0]  OFS_DIM_LAST    = 4'h8;
  localparam logic [3:0]  OFS_DET_CFG     = 4'h9;  // detector thresholds
  localparam logic [3:0]  OFS_OPEN_STAT   = 4'hA;  // write 1 to clear
  localparam logic [3:0]  OFS_SHORT_STAT  = 4'hB;  // write 1 to clear
  localparam logic [3:0]  OFS_MISC_STAT   = 4'hC;  // overheat, enable, timebase

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int          CFG_OPEN_LSB    = 0;
  localparam int          CFG_SHORT_LSB   = 2;
  localparam int          CFG_COUNT_LSB   = 4;
  localparam int          MISC_OVH_BIT    = 0;
  localparam int          MISC_EN_BIT     = 1;
  localparam int          MISC_EXT_BIT    = 2;
  localparam logic [7:0]  ALL_CH_RST_OFF  = 8'hFF; // switches off, LEDs on
  localparam logic [7:0]  ALL_CH_RST_ON   = 8'h00; // switches on, LEDs off
  localparam logic [1:0]  OPEN_THR_4V5    = 2'h0;
  localparam logic [1:0]  OPEN_THR_9V     = 2'h1;
  localparam logic [1:0]  OPEN_THR_13V5   = 2'h2;
  localparam logic [1:0]  OPEN_THR_18V    = 2'h3;
  localparam logic [1:0]  SHORT_THR_RST   = 2'h0;  // fixed 1V
  localparam logic [1:0]  SHORT_CNT_RST   = 2'h0;  // single shorted LED
  localparam logic [7:0]  DIM_RST         = 8'h00;
  localparam logic [2:0]  GRP_ALL_PREFIX  = 3'h2;  // 010
  localparam logic [2:0]  GRP_CH_PREFIX   = 3'h5;  // 101
  localparam logic [10:0] CH_PHASE_STEP   = 11'h100; // one eighth of 2048

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int          CLK_HZ          = 20_000_000;
  localparam int          DIM_CYCLE_TICKS = 2048;
  localparam int          INT_OSC_HZ      = 1_000_000;
  localparam int          INT_DIV_CYC     = CLK_HZ / INT_OSC_HZ;
  localparam int          EXT_IDLE_NS     = 10_000;
  localparam int          EXT_IDLE_CYC    = EXT_IDLE_NS / (1_000_000_000 / CLK_HZ);

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic [7:0] open_det;
    logic [7:0] short_det;
    logic       overheat;
  } fault_in_t;

  typedef struct packed {
    logic [1:0] open_thr;
    logic [1:0] short_thr;
    logic [1:0] short_cnt;
  } det_cfg_t;

endpackage : dimmer_pkg

`default_nettype wire

// *** rtl/led_dimmer_ctrl.sv ***
/*
  Control logic of the eight-channel LED bypass dimmer: register file,
  timebase selection, per-channel dimming counters, fault latching and
  alert handling, enable/undervoltage shutdown.
  Assumes every input is synchronous to CLK_SYS; serial bus framing and
  analog detectors sit outside and meet this block at plain ports.
*/
// Our own choices: the register addresses and the plain strobed port.
`default_nettype none

module led_dimmer_ctrl #(
  parameter bit SWITCHES_ON_VARIANT = 1'b0,
  parameter int INT_DIV             = dimmer_pkg::INT_DIV_CYC,
  parameter int EXT_IDLE            = dimmer_pkg::EXT_IDLE_CYC
) (
  input  wire logic                        CLK_SYS,
  input  wire logic                        RST_N,
  input  wire logic [dimmer_pkg::ADDR_W-1:0] REG_ADDR,
  input  wire logic [dimmer_pkg::DATA_W-1:0] REG_WDATA,
  input  wire logic                        REG_WR,
  input  wire logic                        REG_RD,
  output logic      [dimmer_pkg::DATA_W-1:0] REG_RDATA,
  input  wire logic                        ENABLE_UV_IN,
  input  wire logic                        TIMEBASE_PIN,
  input  wire logic [3:0]                  ADDR_SEL,
  input  wire dimmer_pkg::fault_in_t       FAULT_IN,
  input  wire logic                        ARA_SENT,
  output logic                             ALERT_N_O,
  output logic                             ALERT_N_OE,
  output logic [6:0]                       ALL_GRP_ADDR,
  output logic [6:0]                       CH_GRP_ADDR,
  output logic [7:0]                       SWITCH_ON,
  output dimmer_pkg::det_cfg_t             DET_CFG
);
  import dimmer_pkg::*;

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  if (INT_DIV < 2 || INT_DIV > 65535) begin : g_bad_div
    $error("INT_DIV out of range");
  end
  if (EXT_IDLE < 4 || EXT_IDLE > 65535) begin : g_bad_idle
    $error("EXT_IDLE out of range");
  end

  localparam logic [7:0]  ALL_CH_RST   = SWITCHES_ON_VARIANT ? ALL_CH_RST_ON : ALL_CH_RST_OFF;
  localparam logic [1:0]  OPEN_THR_RST = SWITCHES_ON_VARIANT ? OPEN_THR_9V : OPEN_THR_18V;
  localparam logic [15:0] DIV_LAST     = 16'(INT_DIV - 1);
  localparam logic [15:0] IDLE_LAST    = 16'(EXT_IDLE - 1);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [7:0]            all_ch;     // 1: LED on
    logic [7:0][7:0]       dim;        // per-channel dimming values
    logic [7:0]            dim_sel;    // channel follows its dimming value
    det_cfg_t              cfg;
    logic [7:0]            open_f;
    logic [7:0]            short_f;
    logic                  ovh_f;
    logic                  alert;      // alert pending
    logic [7:0][CNT_W-1:0] cnt;
    logic [7:0]            led_on;
    logic [15:0]           div;
    logic [15:0]           idle;
    logic                  ext;        // external timebase in use
    logic                  tb_q;       // timebase pin last sample
    logic                  en_q;       // enable last sample
    logic [7:0]            rdata;
    logic                  alert_n_oe;
    logic [6:0]            all_addr;
    logic [6:0]            ch_addr;
    logic [7:0]            sw_on;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // power-on contents, also used on enable rising edge
  function automatic state_t por_state(input logic en_now, input logic tb_now);
    state_t s;
    s            = '0;
    s.all_ch     = ALL_CH_RST;
    s.cfg.open_thr  = OPEN_THR_RST;
    s.cfg.short_thr = SHORT_THR_RST;
    s.cfg.short_cnt = SHORT_CNT_RST;
    for (int i = 0; i < NUM_CH; i++) begin
      s.dim[i] = DIM_RST;
      s.cnt[i] = CNT_W'(CH_PHASE_STEP * 11'(i));
      s.led_on[i] = 1'b1;
    end
    s.en_q       = en_now;
    s.tb_q       = tb_now;
    return s;
  endfunction : por_state

  // read mux for the register port
  function automatic logic [7:0] read_reg(input state_t s, input logic [3:0] a,
                                          input logic en);
    logic [7:0] d;
    d = 8'h00;
    if (a == OFS_ALL_CH) begin
      d = s.all_ch;
    end else if (a >= OFS_DIM_FIRST && a <= OFS_DIM_LAST) begin
      d = s.dim[3'(a - OFS_DIM_FIRST)];
    end else if (a == OFS_DET_CFG) begin
      d = {2'h0, s.cfg.short_cnt, s.cfg.short_thr, s.cfg.open_thr};
    end else if (a == OFS_OPEN_STAT) begin
      d = en ? s.open_f : 8'hFF;
    end else if (a == OFS_SHORT_STAT) begin
      d = en ? s.short_f : 8'hFF;
    end else if (a == OFS_MISC_STAT) begin
      d[MISC_OVH_BIT] = s.ovh_f;
      d[MISC_EN_BIT]  = en;
      d[MISC_EXT_BIT] = s.ext;
    end
    return d;
  endfunction : read_reg

  // ****************************************************************
  // next-state logic
  // ****************************************************************
  always_comb begin
    logic       en;
    logic       tick;
    logic       tb_edge;
    logic       int_tick;
    logic [7:0] new_f;
    logic [7:0] wr_clr;
    st_nxt   = st_r;
    en       = ENABLE_UV_IN;
    tb_edge  = TIMEBASE_PIN && !st_r.tb_q;
    int_tick = (st_r.div == DIV_LAST);
    wr_clr   = 8'h00;
    tick     = 1'b0;
    new_f    = 8'h00;

    // timebase: internal divider unless the pin toggles
    st_nxt.tb_q = TIMEBASE_PIN;
    st_nxt.div  = int_tick ? 16'h0000 : st_r.div + 16'h0001;
    if (tb_edge) begin
      st_nxt.ext  = 1'b1;
      st_nxt.idle = 16'h0000;
    end else if (st_r.idle == IDLE_LAST) begin
      st_nxt.ext  = 1'b0;
    end else begin
      st_nxt.idle = st_r.idle + 16'h0001;
    end
    tick = st_r.ext ? tb_edge : int_tick;

    // dimming counters and LED phase
    for (int i = 0; i < NUM_CH; i++) begin
      if (tick) begin
        st_nxt.cnt[i] = st_r.cnt[i] + 11'h001;
        if (st_r.cnt[i] == 11'h7FF) begin
          st_nxt.led_on[i] = 1'b1;
        end else if (st_r.cnt[i] + 11'h001 == {st_r.dim[i], 3'h0}) begin
          st_nxt.led_on[i] = 1'b0;
        end
      end
    end

    // register writes, accepted in shutdown too
    if (REG_WR) begin
      if (REG_ADDR == OFS_ALL_CH) begin
        st_nxt.all_ch  = REG_WDATA;
        st_nxt.dim_sel = 8'h00;                             // last write wins
      end else if (REG_ADDR >= OFS_DIM_FIRST && REG_ADDR <= OFS_DIM_LAST) begin
        st_nxt.dim[3'(REG_ADDR - OFS_DIM_FIRST)]     = REG_WDATA;
        st_nxt.dim_sel[3'(REG_ADDR - OFS_DIM_FIRST)] = 1'b1;
      end else if (REG_ADDR == OFS_DET_CFG) begin
        st_nxt.cfg.open_thr  = REG_WDATA[CFG_OPEN_LSB +: 2];
        st_nxt.cfg.short_thr = REG_WDATA[CFG_SHORT_LSB +: 2];
        st_nxt.cfg.short_cnt = REG_WDATA[CFG_COUNT_LSB +: 2];
      end else if (REG_ADDR == OFS_OPEN_STAT) begin
        wr_clr = REG_WDATA;
        st_nxt.open_f = st_r.open_f & ~REG_WDATA;
      end else if (REG_ADDR == OFS_SHORT_STAT) begin
        wr_clr = REG_WDATA;
        st_nxt.short_f = st_r.short_f & ~REG_WDATA;
      end else if (REG_ADDR == OFS_MISC_STAT) begin
        wr_clr[MISC_OVH_BIT] = REG_WDATA[MISC_OVH_BIT];
        if (REG_WDATA[MISC_OVH_BIT]) begin
          st_nxt.ovh_f = 1'b0;
        end
      end
      if (wr_clr != 8'h00) begin
        st_nxt.alert = 1'b0;
      end
    end
    if (ARA_SENT) begin
      st_nxt.alert = 1'b0;
    end

    // fault latching while enabled; a new fault wins over a clear
    if (en) begin
      new_f = (FAULT_IN.open_det & ~st_r.open_f) | (FAULT_IN.short_det & ~st_r.short_f);
      st_nxt.open_f  = st_nxt.open_f | FAULT_IN.open_det;
      st_nxt.short_f = st_nxt.short_f | FAULT_IN.short_det;
      st_nxt.ovh_f   = st_nxt.ovh_f | FAULT_IN.overheat;
      if (new_f != 8'h00 || (FAULT_IN.overheat && !st_r.ovh_f)) begin
        st_nxt.alert = 1'b1;
      end
    end else begin
      st_nxt.alert = 1'b0;
    end

    // read data stands the cycle after the strobe only
    st_nxt.rdata = REG_RD ? read_reg(st_r, REG_ADDR, en) : 8'h00;

    // registered pin values
    st_nxt.alert_n_oe = en && st_nxt.alert;
    st_nxt.all_addr   = {GRP_ALL_PREFIX, ADDR_SEL};
    st_nxt.ch_addr    = {GRP_CH_PREFIX, ADDR_SEL};
    for (int i = 0; i < NUM_CH; i++) begin
      if (!en) begin
        st_nxt.sw_on[i] = 1'b0;
      end else if (st_nxt.open_f[i]) begin
        st_nxt.sw_on[i] = 1'b1;
      end else if (st_nxt.dim_sel[i]) begin
        st_nxt.sw_on[i] = !st_nxt.led_on[i];
      end else begin
        st_nxt.sw_on[i] = !st_nxt.all_ch[i];
      end
    end

    // enable rising edge restores power-on state
    st_nxt.en_q = en;
    if (en && !st_r.en_q) begin
      st_nxt = por_state(1'b1, TIMEBASE_PIN);
      st_nxt.all_addr = {GRP_ALL_PREFIX, ADDR_SEL};
      st_nxt.ch_addr  = {GRP_CH_PREFIX, ADDR_SEL};
      st_nxt.sw_on    = ~ALL_CH_RST;
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      st_r <= por_state(1'b0, 1'b0);
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flip-flops, except ALERT_N_O tied low
  assign REG_RDATA    = st_r.rdata;
  assign ALERT_N_O    = 1'b0;         // open drain, only ever pulls low
  assign ALERT_N_OE   = st_r.alert_n_oe;
  assign ALL_GRP_ADDR = st_r.all_addr;
  assign CH_GRP_ADDR  = st_r.ch_addr;
  assign SWITCH_ON    = st_r.sw_on;
  assign DET_CFG      = st_r.cfg;

endmodule : led_dimmer_ctrl

`default_nettype wire

// *** tb/dimmer_ctrl_sva.sv ***
/*
  Port checks for the dimmer control block.
  Assumes a bind onto led_dimmer_ctrl and one clock domain.
*/
`default_nettype none

module dimmer_ctrl_sva (
  input wire logic                 CLK_SYS,
  input wire logic                 RST_N,
  input wire logic [3:0]           REG_ADDR,
  input wire logic                 REG_WR,
  input wire logic                 REG_RD,
  input wire logic [7:0]           REG_RDATA,
  input wire logic                 ENABLE_UV_IN,
  input wire logic [3:0]           ADDR_SEL,
  input wire dimmer_pkg::fault_in_t FAULT_IN,
  input wire logic                 ARA_SENT,
  input wire logic                 ALERT_N_OE,
  input wire logic [6:0]           ALL_GRP_ADDR,
  input wire logic [6:0]           CH_GRP_ADDR,
  input wire logic [7:0]           SWITCH_ON
);
  timeunit 1ns;
  timeprecision 1ps;
  import dimmer_pkg::*;

  // ********
  // checks
  // ********
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  a_shut_switch_off: assert property (!ENABLE_UV_IN |=> SWITCH_ON == 8'h00)
    else $error("switches not off in shutdown");
  a_shut_alert_off: assert property (!ENABLE_UV_IN |=> !ALERT_N_OE)
    else $error("alert driven in shutdown");
  a_alert_cause: assert property ($rose(ALERT_N_OE) |-> $past(|FAULT_IN))
    else $error("alert raised without a fault");
  a_alert_release: assert property ($fell(ALERT_N_OE)
    |-> $past(ARA_SENT || REG_WR || !ENABLE_UV_IN))
    else $error("alert released without cause");
  a_open_bypass: assert property (ENABLE_UV_IN && $past(ENABLE_UV_IN)
    && $past(ENABLE_UV_IN, 2)
    |=> (SWITCH_ON & $past(FAULT_IN.open_det)) == $past(FAULT_IN.open_det))
    else $error("open fault channel not bypassed");
  a_all_grp_addr: assert property ($past(RST_N)
    |-> ALL_GRP_ADDR == {3'h2, $past(ADDR_SEL)})
    else $error("all-channel address wrong");
  a_ch_grp_addr: assert property ($past(RST_N)
    |-> CH_GRP_ADDR == {3'h5, $past(ADDR_SEL)})
    else $error("per-channel address wrong");
  a_rdata_quiet: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
    else $error("read data outside read slot");
  a_unmapped_zero: assert property ($past(REG_RD) && $past(REG_ADDR) > 4'hC
    |-> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_shut_status_ones: assert property (REG_RD && !ENABLE_UV_IN
    && (REG_ADDR == OFS_OPEN_STAT || REG_ADDR == OFS_SHORT_STAT) |=> REG_RDATA == 8'hFF)
    else $error("status not all ones in shutdown");

endmodule : dimmer_ctrl_sva

bind led_dimmer_ctrl dimmer_ctrl_sva i_sva (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
  .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .ENABLE_UV_IN(ENABLE_UV_IN), .ADDR_SEL(ADDR_SEL), .FAULT_IN(FAULT_IN),
  .ARA_SENT(ARA_SENT), .ALERT_N_OE(ALERT_N_OE), .ALL_GRP_ADDR(ALL_GRP_ADDR),
  .CH_GRP_ADDR(CH_GRP_ADDR), .SWITCH_ON(SWITCH_ON));

`default_nettype wire

// *** tb/timebase_src.sv ***
/*
  External dimming clock source on the timebase pin.
  Assumes the system clock; pin rests low while not running.
*/
`default_nettype none

module timebase_src #(
  parameter int HALF = 2
) (
  input  wire logic clk_sys,
  input  wire logic run,
  output logic      pin
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;

  // toggle every HALF clocks while running
  always @(posedge clk_sys) begin
    if (!run) begin
      pin <= 1'b0;
      cnt <= 0;
    end else if (cnt == HALF - 1) begin
      pin <= ~pin;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : timebase_src

`default_nettype wire

// *** tb/testbench.sv ***
/*
  Self-checking bench for the dimmer control block.
  Assumes INT_DIV 2, external source period of 4 clocks.
*/
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import dimmer_pkg::*;

  logic       clk_sys, rst_n, reg_wr, reg_rd, enable_uv_in, ara_sent, run_ext, timebase_pin;
  logic [3:0] reg_addr, addr_sel;
  logic [7:0] reg_wdata, reg_rdata, switch_on;
  logic [6:0] all_grp_addr, ch_grp_addr;
  logic       alert_n_o, alert_n_oe;
  fault_in_t  fault_in;
  det_cfg_t   det_cfg;
  det_cfg_t   det_cfg_v1;
  logic [7:0] switch_on_v1;
  int         failures, compares;

  led_dimmer_ctrl #(.SWITCHES_ON_VARIANT(1'b0), .INT_DIV(2), .EXT_IDLE(8)) i_dut (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .ENABLE_UV_IN(enable_uv_in),
    .TIMEBASE_PIN(timebase_pin), .ADDR_SEL(addr_sel), .FAULT_IN(fault_in),
    .ARA_SENT(ara_sent), .ALERT_N_O(alert_n_o), .ALERT_N_OE(alert_n_oe),
    .ALL_GRP_ADDR(all_grp_addr), .CH_GRP_ADDR(ch_grp_addr), .SWITCH_ON(switch_on),
    .DET_CFG(det_cfg));
  timebase_src i_src (.clk_sys(clk_sys), .run(run_ext), .pin(timebase_pin));
  // second variant, same stimulus, only its defaults are compared
  led_dimmer_ctrl #(.SWITCHES_ON_VARIANT(1'b1), .INT_DIV(2), .EXT_IDLE(8)) i_dut_v1 (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(), .ENABLE_UV_IN(enable_uv_in),
    .TIMEBASE_PIN(timebase_pin), .ADDR_SEL(addr_sel), .FAULT_IN(fault_in),
    .ARA_SENT(ara_sent), .ALERT_N_O(), .ALERT_N_OE(), .ALL_GRP_ADDR(), .CH_GRP_ADDR(),
    .SWITCH_ON(switch_on_v1), .DET_CFG(det_cfg_v1));

  // ********
  // helpers
  // ********
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic stop_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      $display("Error %s expected %0h seen %0h", what, exp, got);
      failures++;
    end
  endtask : chk

  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    chk(what, {24'h0, exp}, {24'h0, reg_rdata});
  endtask : rd

  // wait for a rising switch bit, bounded
  task automatic rise(input int b);
    logic p;
    p = switch_on[b];
    for (int i = 0; i < 20000; i++) begin
      tick(1);
      if (switch_on[b] === 1'b1 && p === 1'b0) return;
      p = switch_on[b];
    end
    failures++;
    $display("Error switch rise expected within 20000 cycles seen none");
  endtask : rise

  task automatic span(input int a, input int b, input int exp, input string what);
    time t0;
    rise(a);
    t0 = $time;
    rise(b);
    chk(what, exp, 32'(($time - t0) / 50));
  endtask : span

  // ********
  // tests
  // ********
  initial begin
    {rst_n, reg_wr, reg_rd, enable_uv_in, ara_sent, run_ext} = 6'h00;
    {reg_addr, reg_wdata, fault_in, failures, compares} = '0;
    addr_sel = 4'hF;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    tick(2);
    chk("all group address", 32'h2F, all_grp_addr);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_sys);
      addr_sel <= 4'(i);
      tick(2);
      chk("all group address", {25'h0, 3'h2, 4'(i)}, all_grp_addr);
      chk("channel group address", {25'h0, 3'h5, 4'(i)}, ch_grp_addr);
    end
    rd(OFS_OPEN_STAT, 8'hFF, "open status");
    rd(OFS_SHORT_STAT, 8'hFF, "short status");
    @(posedge clk_sys);
    fault_in <= '1;
    tick(3);
    chk("alert in shutdown", 32'h0, alert_n_oe);
    chk("switches in shutdown", 32'h0, switch_on);
    @(posedge clk_sys);
    fault_in <= '0;
    wr(OFS_DET_CFG, 8'h3C);
    rd(OFS_DET_CFG, 8'h3C, "config written in shutdown");
    @(posedge clk_sys);
    enable_uv_in <= 1'b1;
    tick(3);
    rd(OFS_DET_CFG, 8'h03, "config after enable");
    rd(OFS_ALL_CH, 8'hFF, "all-channel bits after enable");
    rd(OFS_OPEN_STAT, 8'h00, "open status after enable");
    chk("switches after enable", 32'h0, switch_on);
    chk("short count default", 32'h0, det_cfg.short_cnt);
    chk("detector config pins", 32'h30, det_cfg);
    chk("variant switches after enable", 32'hFF, switch_on_v1);
    chk("variant open threshold", 32'h1, det_cfg_v1.open_thr);
    wr(OFS_DET_CFG, 8'h16);
    rd(OFS_DET_CFG, 8'h16, "config written while enabled");
    chk("detector config pins", 32'h25, det_cfg);
    @(posedge clk_sys);
    fault_in.open_det[2] <= 1'b1;
    tick(1);
    chk("alert on open fault", 32'h1, alert_n_oe);
    chk("bypass on open fault", 32'h04, switch_on);
    @(posedge clk_sys);
    fault_in.open_det[2] <= 1'b0;
    tick(4);
    chk("bypass held after open fault", 32'h04, switch_on);
    rd(OFS_OPEN_STAT, 8'h04, "open status latched");
    wr(OFS_OPEN_STAT, 8'h04);
    tick(1);
    chk("alert after clear", 32'h0, alert_n_oe);
    chk("bypass after clear", 32'h0, switch_on);
    @(posedge clk_sys);
    fault_in.short_det[5] <= 1'b1;
    @(posedge clk_sys);
    fault_in.short_det[5] <= 1'b0;
    #1;
    chk("alert on short fault", 32'h1, alert_n_oe);
    chk("switches on short fault", 32'h0, switch_on);
    @(posedge clk_sys);
    ara_sent <= 1'b1;
    @(posedge clk_sys);
    ara_sent <= 1'b0;
    #1;
    chk("alert after response", 32'h0, alert_n_oe);
    rd(OFS_SHORT_STAT, 8'h20, "short status kept");
    wr(OFS_SHORT_STAT, 8'h20);
    @(posedge clk_sys);
    fault_in.overheat <= 1'b1;
    @(posedge clk_sys);
    fault_in.overheat <= 1'b0;
    rd(OFS_MISC_STAT, 8'h03, "overheat and enable");
    wr(OFS_MISC_STAT, 8'h01);
    tick(1);
    chk("alert after overheat clear", 32'h0, alert_n_oe);
    for (int a = 13; a < 16; a++) rd(4'(a), 8'h00, "unmapped");
    wr(OFS_DIM_FIRST + 4'h1, 8'h80);
    wr(OFS_DIM_FIRST, 8'h80);
    fault_in.short_det[0] <= 1'b1;
    span(0, 0, 2048 * 2, "internal dimming period");
    span(1, 0, 256 * 2, "neighbour phase offset");
    @(posedge clk_sys);
    run_ext <= 1'b1;
    tick(20);
    rd(OFS_MISC_STAT, 8'h06, "external timebase flag");
    span(0, 0, 2048 * 4, "external dimming period");
    chk("alert on short while dimming", 32'h1, alert_n_oe);
    @(posedge clk_sys);
    enable_uv_in <= 1'b0;
    tick(2);
    chk("switches after disable", 32'h0, switch_on);
    chk("alert pin data", 32'h0, alert_n_o);
    chk("alert after disable", 32'h0, alert_n_oe);
    rd(OFS_SHORT_STAT, 8'hFF, "short status after disable");
    stop_test();
  end

  // watchdog over the whole run
  initial begin
    #2_500_000; // about twice the longest path through the tests
    failures++;
    $display("Error watchdog expected finish seen timeout");
    stop_test();
  end
endmodule : testbench

`default_nettype wire
